// ==== hw/sic_pkg.sv ====
// Shared constants and types for the stepper indexer control block
package sic_pkg;

   // Core clock rate
   localparam int unsigned CLK_HZ        = 100_000_000;
   // Overcurrent qualification time, nanoseconds
   localparam int unsigned OCP_QUAL_NS   = 3000;
   // Same time in core clock cycles, rounded up
   localparam int unsigned OCP_QUAL_CYC  =
      (OCP_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // Indexer position width and table length
   localparam int unsigned POS_W         = 7;
   localparam int unsigned TABLE_LEN     = 128;
   // Home position: fine state 16, 45 degrees
   localparam logic [6:0]  HOME_POS      = 7'h10;

   // Resolution select codes on the mode inputs
   localparam logic [2:0]  MODE_FULL     = 3'h0;
   localparam logic [2:0]  MODE_HALF     = 3'h1;
   localparam logic [2:0]  MODE_QUARTER  = 3'h2;
   localparam logic [2:0]  MODE_EIGHTH   = 3'h3;
   localparam logic [2:0]  MODE_SIXTEENTH = 3'h4;

   // Fine states skipped per step edge at each resolution
   localparam logic [6:0]  INC_FULL      = 7'h20;
   localparam logic [6:0]  INC_HALF      = 7'h10;
   localparam logic [6:0]  INC_QUARTER   = 7'h08;
   localparam logic [6:0]  INC_EIGHTH    = 7'h04;
   localparam logic [6:0]  INC_SIXTEENTH = 7'h02;
   localparam logic [6:0]  INC_FINE      = 7'h01;

   // Power and operating mode of the block
   typedef enum logic [1:0] {
      SIC_PM_OFF   = 2'b00,
      SIC_PM_SLEEP = 2'b01,
      SIC_PM_IDLE  = 2'b10,
      SIC_PM_RUN   = 2'b11
   } sic_pm_t;

   // Pin inputs from the motion controller and analog monitors
   typedef struct packed {
      logic       clear_n;   // clear_in_n
      logic       enable_n;  // output_enable_n
      logic       sleep_n;   // sleep_in_n
      logic       step;      // step edge input
      logic       dir;       // direction level
      logic [2:0] mode;      // resolution select
      logic       overcurrent_trip;       // overcurrent_trip, any transistor
      logic       thermal_trip;       // thermal_trip
      logic       supply_low_lockout;      // supply_low_lockout
   } sic_pins_t;

   // Power stage controls
   typedef struct packed {
      logic bridge_en;  // both bridges driving
      logic out_hiz;    // outputs floated
      logic pump_en;    // charge pump running
      logic aux_en;     // aux_regulator_out enabled
      logic clk_run;    // internal clocks running
   } sic_pwr_t;

   // Winding current targets, percent of full scale
   typedef struct packed {
      logic signed [7:0] cur_a;
      logic signed [7:0] cur_b;
   } sic_cur_t;

   // Values after reset
   localparam sic_pins_t PINS_RST = '0;
   // Bridges off in reset, so the outputs float as well
   localparam sic_pwr_t  PWR_RST  = '{bridge_en: 1'b0, out_hiz: 1'b1, pump_en: 1'b0,
                                      aux_en: 1'b0, clk_run: 1'b0};

endpackage : sic_pkg

// ==== hw/sic_wave_table.sv ====
// Winding current lookup for one indexer position
`timescale 1ns/1ps
module sic_wave_table (
   input  wire logic [6:0]    pos,
   output sic_pkg::sic_cur_t  cur
);

   // Quarter wave magnitude, 0 to 32 fine states
   function automatic logic [7:0] quarter_mag(input logic [5:0] r);
      logic [7:0] m;
      m = 8'h00;
      case (r)
         6'h00, 6'h01, 6'h02: m = 8'h64;
         6'h03: m = 8'h63;
         6'h04: m = 8'h62;
         6'h05: m = 8'h61;
         6'h06: m = 8'h60;
         6'h07: m = 8'h5e;
         6'h08: m = 8'h5c;
         6'h09: m = 8'h5a;
         6'h0a: m = 8'h58;
         6'h0b: m = 8'h56;
         6'h0c: m = 8'h53;
         6'h0d: m = 8'h50;
         6'h0e: m = 8'h4d;
         6'h0f: m = 8'h4a;
         6'h10: m = 8'h47;
         6'h11: m = 8'h43;
         6'h12: m = 8'h3f;
         6'h13: m = 8'h3c;
         6'h14: m = 8'h38;
         6'h15: m = 8'h33;
         6'h16: m = 8'h2f;
         6'h17: m = 8'h2b;
         6'h18: m = 8'h26;
         6'h19: m = 8'h22;
         6'h1a: m = 8'h1d;
         6'h1b: m = 8'h18;
         6'h1c: m = 8'h14;
         6'h1d: m = 8'h0f;
         6'h1e: m = 8'h0a;
         6'h1f: m = 8'h05;
         default: m = 8'h00;
      endcase
      return m;
   endfunction : quarter_mag

   // Signed cosine in percent, 128 states per electrical turn
   function automatic logic [7:0] cos_pct(input logic [6:0] k);
      logic [5:0] r;
      logic [5:0] rr;
      r  = {1'b0, k[4:0]};
      rr = 6'h20 - r;
      case (k[6:5])
         2'b00:   cos_pct = quarter_mag(r);
         2'b01:   cos_pct = 8'h00 - quarter_mag(rr);
         2'b10:   cos_pct = 8'h00 - quarter_mag(r);
         default: cos_pct = quarter_mag(rr);
      endcase
   endfunction : cos_pct

   // Winding A follows cosine, winding B sine
   always_comb begin
      cur.cur_a = cos_pct(pos);
      cur.cur_b = cos_pct(pos - 7'h20);
   end

endmodule : sic_wave_table

// ==== hw/sic_stepper_indexer_control.sv ====
// Step/direction indexer, power control and fault handling of the driver
//
// Notes on behaviour
// R01: Clear low resets logic, indexer home.
// R02: Clear low: bridges off, steps ignored.
// R03: Enable low: bridges on, steps accepted.
// R04: Enable high: bridges off, outputs float.
// R05: Sleep low: bridges, pump, regulator, clocks off.
// R06: In sleep every other input ignored; here clear and lockout still act in sleep.
// R07: Controller waits about 1 ms after sleep.
// R08: Controller drives sleep and clear high.
// R09: Long current limit: bridges off, fault low.
// R10: Overcurrent shutdown latches until clear.
// R11: Every short kind uses same shutdown.
// R12: Thermal: bridges off, fault, self resume.
// R13: Supply low: all off, logic reset.
// R14: One table move per step edge.
// R15: Direction level picks move direction.
// R16: Mode pins pick full to 1/32.
// R17: Table of 128 fine current states.
// R18: Position wraps; coarse modes skip states.
// R19: Fault released once its cause ends.
`timescale 1ns/1ps
module sic_stepper_indexer_control #(
   parameter int unsigned OCP_QUAL_CYC = sic_pkg::OCP_QUAL_CYC
) (
   input  wire logic               core_clk,
   input  wire logic               resetn,
   input  wire sic_pkg::sic_pins_t pins_in,
   output sic_pkg::sic_pwr_t       pwr_out,
   output sic_pkg::sic_cur_t       cur_out,
   output logic [6:0]              pos_out,
   output logic                    fault_out_n_o,
   output logic                    fault_out_n_oe
);

   // Width of the overcurrent qualification counter
   // Sized from the parameter so a short count in simulation still fits
   localparam int unsigned OCW = $clog2(OCP_QUAL_CYC + 1);
   // Last count before the trip is qualified
   localparam logic [OCW-1:0] OC_LAST = OCW'(OCP_QUAL_CYC - 1);
   // Pin group width for the synchroniser
   // Follows the pin struct, so adding a pin needs no edit here
   localparam int unsigned PW = $bits(sic_pkg::sic_pins_t);

   // Step increment for a resolution code
   // Coarse modes skip fine states, so every mode walks one table
   function automatic logic [6:0] step_inc(input logic [2:0] m);
      case (m)
         sic_pkg::MODE_FULL:      step_inc = sic_pkg::INC_FULL;
         sic_pkg::MODE_HALF:      step_inc = sic_pkg::INC_HALF;
         sic_pkg::MODE_QUARTER:   step_inc = sic_pkg::INC_QUARTER;
         sic_pkg::MODE_EIGHTH:    step_inc = sic_pkg::INC_EIGHTH;
         sic_pkg::MODE_SIXTEENTH: step_inc = sic_pkg::INC_SIXTEENTH;
         // Remaining codes all give 1/32
         default:                 step_inc = sic_pkg::INC_FINE;
      endcase
   endfunction : step_inc

   // Pin synchroniser
   // Every pin, step included, is asynchronous to core_clk; nothing
   // downstream reads a raw pin, at the price of two cycles of latency
   logic [PW-1:0]      meta_q;    // first stage, read only by second
   logic [PW-1:0]      sync_q;    // second stage, safe to use
   sic_pkg::sic_pins_t s;         // synchronised pin view

   // Two flops per pin; every input is asynchronous to the core clock
   // Reset values are all low, the idle level of step, so no false step edge
   generate
      for (genvar i = 0; i < PW; i++) begin : g_sync
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               meta_q[i] <= sic_pkg::PINS_RST[i];
               sync_q[i] <= sic_pkg::PINS_RST[i];
            end else begin
               meta_q[i] <= pins_in[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   // Named view of the synchronised pins
   // Only this view is read below; meta_q feeds sync_q alone
   assign s = sic_pkg::sic_pins_t'(sync_q);

   // Operating mode
   // One decoded mode drives the indexer, the fault logic and the power
   // controls, though the fault freeze reads it one cycle late through pm_q
   sic_pkg::sic_pm_t pm_q;   // registered mode
   sic_pkg::sic_pm_t pm_d;   // mode from current pins

   // Decode the mode; supply lockout outranks everything
   // Clear and lockout win over sleep, sleep wins over enable
   always_comb begin
      // Defaults to run; every branch below overrides it
      pm_d = sic_pkg::SIC_PM_RUN;
      if (s.supply_low_lockout || !s.clear_n) begin
         // R13 supply lockout resets
         // R01 clear resets logic
         pm_d = sic_pkg::SIC_PM_OFF;
      end else if (!s.sleep_n) begin
         // R05 enter low power
         pm_d = sic_pkg::SIC_PM_SLEEP;
      end else if (s.enable_n) begin
         // R04 bridges held off
         pm_d = sic_pkg::SIC_PM_IDLE;
      end else begin
         // R03 enabled and stepping
         pm_d = sic_pkg::SIC_PM_RUN;
      end
   end

   // Mode register
   // Read by the fault freeze, which acts once sleep has taken hold
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pm_q <= sic_pkg::SIC_PM_OFF;
      end else begin
         pm_q <= pm_d;
      end
   end

   // Indexer
   // Position counts fine states 0 to 127; the table state is the same
   // Position and edge state, with their next values
   logic [6:0] pos_q;        // fine table position
   logic [6:0] pos_d;
   logic       step_prev_q;  // step level last cycle
   logic       step_prev_d;
   logic       step_rise;    // recognised rising edge
   logic [6:0] inc;          // fine states per edge

   // Edge and increment decode
   // The edge flop resets low, the idle level of the step pin,
   // so releasing reset with the pin low shows no false edge
   always_comb begin
      // R14 rising edge only
      step_rise = s.step && !step_prev_q;
      // R16 resolution from mode pins
      inc       = step_inc(s.mode);
   end

   // Next position
   // A mode change acts from the next edge on; no realignment
   always_comb begin
      pos_d       = pos_q;
      // Tracked in every mode so a level held across sleep is no edge
      step_prev_d = s.step;
      case (pm_d)
         sic_pkg::SIC_PM_OFF: begin
            // R01 home on clear or lockout
            pos_d = sic_pkg::HOME_POS;
         end
         sic_pkg::SIC_PM_RUN: begin
            if (step_rise) begin
               // Overcurrent and thermal faults stop the bridges, never the indexer
               // R15 direction picks the sense
               // R18 wraps modulo 128 by width
               if (s.dir) begin
                  pos_d = pos_q + inc;
               end else begin
                  pos_d = pos_q - inc;
               end
            end
         end
         // Idle and sleep hold the position as it stands
         // R02 R04 R06 steps ignored otherwise
         default: pos_d = pos_q;
      endcase
   end

   // Indexer registers
   // Reset puts the position home, the same as a clear
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pos_q       <= sic_pkg::HOME_POS;
         step_prev_q <= 1'b0;
      end else begin
         pos_q       <= pos_d;
         step_prev_q <= step_prev_d;
      end
   end

   // R17 current targets for the position
   // Fed the next position so the registered table output
   // lines up with pos_q in the same cycle
   sic_pkg::sic_cur_t cur_d;   // table output, unregistered

   sic_wave_table u_wave (
      .pos (pos_d),
      .cur (cur_d)
   );

   // Fault handling
   // Overcurrent is qualified and latched; thermal and lockout follow
   // their inputs, so only the overcurrent path holds state of its own
   // Overcurrent counter, latch and pin level
   logic [OCW-1:0] oc_cnt_q;    // cycles the limit has been active
   logic [OCW-1:0] oc_cnt_d;
   logic           oc_lat_q;    // latched overcurrent shutdown
   logic           oc_lat_d;
   logic           oc_set;      // qualification reached
   logic           fault_q;     // fault pin pulled low
   logic           fault_d;

   // Qualify the current limit, latch, and form the fault level
   // The count restarts whenever the limit drops for one cycle, and
   // clears outside run so idle or sleep never qualifies a trip
   always_comb begin
      // Defaults: count cleared, no trip
      oc_cnt_d = '0;
      oc_set   = 1'b0;
      // R11 one trip input covers every short
      if (s.overcurrent_trip && pm_d == sic_pkg::SIC_PM_RUN && !oc_lat_q) begin
         if (oc_cnt_q == OC_LAST) begin
            // R09 limit persisted too long
            oc_set   = 1'b1;
            // Count holds its last value for one cycle, then clears once the latch sets
            oc_cnt_d = oc_cnt_q;
         end else begin
            oc_cnt_d = oc_cnt_q + OCW'(1);
         end
      end
      // R10 latch until clear; the clear beats a new trip
      // Lockout and clear both map to the off mode, so both release it
      oc_lat_d = oc_set || (oc_lat_q && pm_d != sic_pkg::SIC_PM_OFF);
      if (pm_q == sic_pkg::SIC_PM_SLEEP) begin
         // R06 clocks halted, fault frozen
         fault_d = fault_q;
      end else if (s.supply_low_lockout) begin
         // R13 all circuitry off, pin released
         // Limitation: a fault present at lockout is not reported
         fault_d = 1'b0;
      end else begin
         // Thermal never latches; the pin follows the sensor both ways
         // R12 thermal follows its input
         // R19 released when cause is gone
         fault_d = oc_lat_d || s.thermal_trip;
      end
   end

   // Fault registers
   // fault_q feeds the sleep freeze; the pin has a flop of its own
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         oc_cnt_q <= '0;
         oc_lat_q <= 1'b0;
         fault_q  <= 1'b0;
      end else begin
         oc_cnt_q <= oc_cnt_d;
         oc_lat_q <= oc_lat_d;
         fault_q  <= fault_d;
      end
   end

   // Output stage
   // Every output but the tied-low fault data leaves from a flop, one cycle after decode
   sic_pkg::sic_pwr_t pwr_q;   // registered power controls
   sic_pkg::sic_pwr_t pwr_d;
   sic_pkg::sic_cur_t cur_q;   // registered current targets
   logic              fo_oe_q; // fault pin driven low
   logic              bridges_on;

   // Power stage controls from mode and faults
   always_comb begin
      // R02 R04 R09 R12 any of these keeps bridges off
      bridges_on = (pm_d == sic_pkg::SIC_PM_RUN) && !oc_lat_d && !s.thermal_trip;
      pwr_d.bridge_en = bridges_on;
      // out_hiz is the exact complement of bridge_en at all times
      // R04 outputs float whenever not driving
      pwr_d.out_hiz   = !bridges_on;
      // Supplies keep running under clear and idle, so leaving
      // either needs no settle time
      // R05 pump, regulator, clocks stop in sleep
      // R13 and under supply lockout
      pwr_d.pump_en   = (pm_d != sic_pkg::SIC_PM_SLEEP) && !s.supply_low_lockout;
      pwr_d.aux_en    = (pm_d != sic_pkg::SIC_PM_SLEEP) && !s.supply_low_lockout;
      pwr_d.clk_run   = (pm_d != sic_pkg::SIC_PM_SLEEP) && !s.supply_low_lockout;
   end

   // Output registers; every top output but fault_out_n_o leaves from a flop
   // cur_q resets to zero, not the home value: no winding current
   // is asked for until reset is released
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pwr_q   <= sic_pkg::PWR_RST;
         cur_q   <= '0;
         fo_oe_q <= 1'b0;
      end else begin
         pwr_q   <= pwr_d;
         cur_q   <= cur_d;
         fo_oe_q <= fault_d;
      end
   end

   // Open-drain fault pin: only ever pulls low
   // Data is tied low; the enable alone decides whether it pulls
   assign fault_out_n_o  = 1'b0;
   assign fault_out_n_oe = fo_oe_q;
   assign pwr_out        = pwr_q;
   assign cur_out        = cur_q;
   assign pos_out        = pos_q;

endmodule : sic_stepper_indexer_control

// ==== bench/sic_stepper_indexer_control_props.sv ====
// Pin-to-output checks of the stepper indexer control block
`timescale 1ns/1ps
module sic_ctrl_props #(
   parameter int unsigned OCP_QUAL_CYC = sic_pkg::OCP_QUAL_CYC
) (
   input wire logic               core_clk,
   input wire logic               resetn,
   input wire sic_pkg::sic_pins_t pins_in,
   input wire sic_pkg::sic_pwr_t  pwr_out,
   input wire sic_pkg::sic_cur_t  cur_out,
   input wire logic [6:0]         pos_out,
   input wire logic               fault_out_n_o,
   input wire logic               fault_out_n_oe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Run of sampled overcurrent cycles
   logic [15:0] ocp_cnt_q;
   logic [15:0] ocp_cnt_d;
   // Counts while the pin is high, restarts when it drops
   always_comb begin
      ocp_cnt_d = pins_in.overcurrent_trip ? ocp_cnt_q + 16'h0001 : 16'h0000;
   end
   // Counter register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ocp_cnt_q <= 16'h0000;
      end else begin
         ocp_cnt_q <= ocp_cnt_d;
      end
   end
   // Four samples cover the two sync flops plus the output register
   sequence s_no_step;
      (!pins_in.step && pins_in.clear_n && !pins_in.supply_low_lockout)[*4];
   endsequence
   sequence s_latched;
      (fault_out_n_oe && !pins_in.thermal_trip && pins_in.clear_n && !pins_in.supply_low_lockout)[*5];
   endsequence
   a_clear_homes: assert property ((!pins_in.clear_n)[*4] |=> pos_out == 7'h10)
      else $error("position not home under clear");
   a_clear_bridge_off: assert property ((!pins_in.clear_n)[*4] |=> !pwr_out.bridge_en)
      else $error("bridges on under clear");
   a_idle_floats: assert property (pins_in.enable_n[*4] |=> pwr_out.out_hiz)
      else $error("outputs not floated when disabled");
   a_hiz_follows: assert property (pwr_out.out_hiz == !pwr_out.bridge_en)
      else $error("float and bridge enable disagree");
   a_sleep_stops: assert property ((!pins_in.sleep_n && pins_in.clear_n && !pins_in.supply_low_lockout)[*4]
      |=> !pwr_out.pump_en && !pwr_out.clk_run && !pwr_out.bridge_en)
      else $error("power not stopped in sleep");
   a_aux_pump_pair: assert property (pwr_out.pump_en == pwr_out.aux_en
      && pwr_out.aux_en == pwr_out.clk_run)
      else $error("pump, regulator and clock disagree");
   a_step_only_moves: assert property (s_no_step |=> $stable(pos_out))
      else $error("position moved without step");
   // Thermal pin seen three samples before the pin enable rises
   a_ocp_qualified: assert property ($rose(fault_out_n_oe) |-> $past(pins_in.thermal_trip, 3)
      || ocp_cnt_q >= 16'(OCP_QUAL_CYC + 2))
      else $error("fault raised without qualified cause");
   a_drain_low: assert property (fault_out_n_o == 1'b0)
      else $error("open drain data not low");
   a_ocp_latch_holds: assert property (s_latched |=> fault_out_n_oe)
      else $error("overcurrent latch released early");
   a_thermal_trips: assert property ((pins_in.thermal_trip && pins_in.sleep_n && pins_in.clear_n
      && !pins_in.supply_low_lockout)[*4] |=> fault_out_n_oe && !pwr_out.bridge_en)
      else $error("thermal fault not shown");
   a_supply_low_lockout_all_off: assert property (pins_in.supply_low_lockout[*4]
      |=> !pwr_out.pump_en && !fault_out_n_oe && pos_out == 7'h10)
      else $error("lockout did not stop and reset");
endmodule : sic_ctrl_props
bind sic_stepper_indexer_control sic_ctrl_props #(.OCP_QUAL_CYC(OCP_QUAL_CYC)) i_props (
   .core_clk(core_clk), .resetn(resetn), .pins_in(pins_in), .pwr_out(pwr_out),
   .cur_out(cur_out), .pos_out(pos_out), .fault_out_n_o(fault_out_n_o),
   .fault_out_n_oe(fault_out_n_oe));

// ==== bench/sic_ctrl_model.sv ====
// Behavioural motion controller that issues step pulses
`timescale 1ns/1ps
module sic_ctrl_model (
   input wire logic core_clk,
   output logic     step
);
   // Step idles low between pulses
   initial step = 1'b0;
   task automatic send(input int n, input int w);
      for (int i = 0; i < n; i++) begin
         repeat (w) @(posedge core_clk);
         #1 step = 1'b1;
         repeat (w) @(posedge core_clk);
         #1 step = 1'b0;
      end
   endtask : send
endmodule : sic_ctrl_model

// ==== bench/tb_stepper_indexer_control.sv ====
// Self-checking bench of the stepper indexer control block
`timescale 1ns/1ps
module tb_stepper_indexer_control;
   logic               core_clk;
   logic               resetn;
   sic_pkg::sic_pins_t pins;     // Bench pin levels
   sic_pkg::sic_pins_t pins_w;   // Pins with model step merged
   logic               step_w;
   sic_pkg::sic_pwr_t  pwr_out;
   sic_pkg::sic_cur_t  cur_out;
   logic [6:0]         pos_out;
   logic               flt_o;
   logic               flt_oe;
   logic [6:0]         exp_pos;  // Expected fine position
   logic [6:0]         incs [8]; // Step size per mode code
   int                 err_count;
   int                 tests_run;
   always_comb begin
      pins_w      = pins;
      pins_w.step = step_w;
   end
   sic_ctrl_model i_ctrl (.core_clk(core_clk), .step(step_w));
   // Short qualification keeps the run brief
   sic_stepper_indexer_control #(.OCP_QUAL_CYC(8)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .pins_in(pins_w), .pwr_out(pwr_out),
      .cur_out(cur_out), .pos_out(pos_out), .fault_out_n_o(flt_o),
      .fault_out_n_oe(flt_oe));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wt
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Power, fault enable and drain data in one word
   task automatic cp(input logic [15:0] exp);
      chk({9'h000, pwr_out, flt_oe, flt_o}, exp);
   endtask : cp
   task automatic stp(input int w);
      i_ctrl.send(1, w);
      wt(4);
      chk({9'h000, pos_out}, {9'h000, exp_pos});
   endtask : stp
   task automatic results();
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results
   // Watchdog far beyond the expected run
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      results();
   end
   initial begin
      pins      = sic_pkg::PINS_RST;
      resetn    = 1'b0;
      err_count = 0;
      tests_run = 0;
      exp_pos   = sic_pkg::HOME_POS;
      incs      = '{sic_pkg::INC_FULL, sic_pkg::INC_HALF, sic_pkg::INC_QUARTER,
                    sic_pkg::INC_EIGHTH, sic_pkg::INC_SIXTEENTH, sic_pkg::INC_FINE,
                    sic_pkg::INC_FINE, sic_pkg::INC_FINE};
      wt(8);
      chk({9'h000, pos_out}, 16'h0010);
      // Bridges off and outputs floated while reset is held
      cp(16'h0020);
      resetn       = 1'b1;
      pins.clear_n = 1'b1;
      pins.sleep_n = 1'b1;
      pins.dir     = 1'b1;
      wt(5);
      cp(16'h005c);
      chk(cur_out, 16'h4747);
      for (int i = 0; i < 3; i++) begin
         exp_pos = exp_pos + sic_pkg::INC_FULL;
         stp(4);
      end
      chk(cur_out, 16'h47b9);
      for (int m = 0; m < 8; m++) begin
         pins.mode = 3'(m);
         exp_pos   = exp_pos + incs[m];
         stp(4);
      end
      pins.dir  = 1'b0;
      pins.mode = sic_pkg::MODE_FULL;
      for (int i = 0; i < 2; i++) begin
         exp_pos = exp_pos - sic_pkg::INC_FULL;
         stp(4 + 5 * i);
      end
      pins.enable_n = 1'b1;
      wt(4);
      cp(16'h003c);
      stp(4);
      pins.enable_n = 1'b0;
      pins.sleep_n  = 1'b0;
      wt(4);
      cp(16'h0020);
      pins.thermal_trip = 1'b1;
      stp(4);
      cp(16'h0020);
      pins.thermal_trip     = 1'b0;
      pins.sleep_n = 1'b1;
      // Short wake settle, scaled down for simulation
      wt(50);
      cp(16'h005c);
      pins.thermal_trip = 1'b1;
      wt(4);
      cp(16'h003e);
      pins.thermal_trip = 1'b0;
      wt(4);
      cp(16'h005c);
      pins.overcurrent_trip = 1'b1;
      wt(4);
      pins.overcurrent_trip = 1'b0;
      wt(4);
      cp(16'h005c);
      pins.overcurrent_trip = 1'b1;
      wt(14);
      cp(16'h003e);
      pins.overcurrent_trip = 1'b0;
      wt(6);
      cp(16'h003e);
      pins.clear_n = 1'b0;
      exp_pos      = sic_pkg::HOME_POS;
      wt(4);
      cp(16'h003c);
      stp(4);
      pins.clear_n = 1'b1;
      wt(4);
      cp(16'h005c);
      exp_pos = exp_pos - sic_pkg::INC_FULL;
      stp(4);
      pins.supply_low_lockout = 1'b1;
      exp_pos   = sic_pkg::HOME_POS;
      wt(4);
      chk({9'h000, pos_out}, {9'h000, exp_pos});
      cp(16'h0020);
      pins.supply_low_lockout = 1'b0;
      wt(4);
      cp(16'h005c);
      results();
   end
endmodule : tb_stepper_indexer_control
